// file: rtl/ddtm_training.sv
// Write leveling and multi purpose register logic of the memory device.
`timescale 1ns/1ps

// How it works
// - MR1 A7 enters and leaves write leveling.
// - Leveling: ODT switches strobe termination only.
// - MR1 A12 disables the output buffers.
// - DQ undefined on leveling entry until feedback.
// - Exit MRS may update A12,A9,A6,A5,A2,A1.
// - ODT accepted only tMOD after entry.
// - Strobe termination on tWLDQSEN after ODT.
// - Each rising strobe edge captures CK level.
// - Feedback on DQ within tWLO of edge; here it comes two register stages after the tWLO count ends.
// - Prime mode drives other DQ bits low.
// - DQ undefined for tMOD after exit MRS.
// - MR3 A2 set enables the MPR.
// - Reads go to MPR, function from A[1:0].
// - RDA in MPR mode ignores auto precharge.
// - Reset still works with MPR enabled.
// - MPR off: reads and writes use array.
// - Location 00 returns alternating calibration pattern.
// - Lane bit 0 carries MPR data.
// - Each byte lane levels its own strobe.
module ddtm_training
  import ddtm_pkg::*;
#(
  parameter int LANES = 2
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite register port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Memory command and control pins.
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  // Sampled clock level and strobe levels, one strobe per lane.
  input wire logic ck_level,
  input wire logic [LANES-1:0] dqs,
  // Data pins, output side; enable is low while driving.
  output logic [8*LANES-1:0] dq_o,
  output logic [LANES-1:0] dq_oe_n,
  // Termination and array access.
  output logic rtt_dqs_on,
  output logic rtt_dq_on,
  output logic array_rd,
  output logic array_wr,
  output logic array_ap,
  output logic mpr_active
);

  function automatic ddtm_cmd_type decode(input logic c, input logic r, input logic a,
                                          input logic w);
    return c ? CMD_NOP : ddtm_cmd_type'({r, a, w});
  endfunction

  function automatic logic [7:0] fld8(input logic [31:0] w, input int lsb);
    return w[lsb +: 8];
  endfunction

  // Bus, configuration and mode register state.
  logic ap_valid_q, ap_valid_d, ap_write_q, ap_write_d;
  logic [7:0] ap_addr_q, ap_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [31:0] tim0_q, tim0_d, tim1_q, tim1_d;
  logic [13:0] mr1_q, mr1_d;
  logic [2:0] mr3_q, mr3_d;
  // Leveling state.
  ddtm_wl_type wl_q, wl_d;
  logic [7:0] cnt_q, cnt_d, dqsen_q, dqsen_d;
  logic rtt_dqs_q, rtt_dqs_d, rtt_dq_q, rtt_dq_d;
  logic [LANES-1:0] dqs_prev_q, dqs_prev_d, smp_q, smp_d, pend_q, pend_d;
  logic [LANES-1:0] fb_q, fb_d, seen_q, seen_d;
  logic [7:0] wlo_q [LANES];
  logic [7:0] wlo_d [LANES];
  // Read burst and output state.
  logic [3:0] beats_q, beats_d;
  logic [2:0] beat_idx_q, beat_idx_d;
  logic [1:0] burst_loc_q, burst_loc_d;
  logic [8*LANES-1:0] dq_q, dq_d;
  logic [LANES-1:0] oe_n_q, oe_n_d;
  logic rd_q, rd_d, wr_q, wr_d, ap_q, ap_d;

  ddtm_cmd_type cmd;
  logic wl_on, odt_ok, qoff, mpr_en, bit_now;
  logic [7:0] lane_val;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign dq_o = dq_q;
  assign dq_oe_n = oe_n_q;
  assign rtt_dqs_on = rtt_dqs_q;
  assign rtt_dq_on = rtt_dq_q;
  assign array_rd = rd_q;
  assign array_wr = wr_q;
  assign array_ap = ap_q;
  assign mpr_active = (beats_q != 4'h0);

  always_comb
  begin
    cmd = decode(cs_n, ras_n, cas_n, we_n);
    ap_valid_d = hsel && hready && htrans[1];
    ap_write_d = hwrite;
    ap_addr_d = haddr[7:0];
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    tim0_d = tim0_q;
    tim1_d = tim1_q;
    mr1_d = mr1_q;
    mr3_d = mr3_q;
    wl_d = wl_q;
    cnt_d = cnt_q;
    dqsen_d = dqsen_q;
    dqs_prev_d = dqs;
    smp_d = smp_q;
    pend_d = pend_q;
    fb_d = fb_q;
    seen_d = seen_q;
    wlo_d = wlo_q;
    beats_d = beats_q;
    beat_idx_d = beat_idx_q;
    burst_loc_d = burst_loc_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    ap_d = 1'b0;
    wl_on = (wl_q == WL_SETTLE) || (wl_q == WL_READY);
    odt_ok = (wl_q == WL_READY);
    qoff = mr1_q[MR1_QOFF_BIT];
    mpr_en = mr3_q[MR3_MPR_BIT];
    bit_now = 1'b0;
    lane_val = 8'h00;

    // Register writes land in the data phase; read data is prepared in the address phase.
    if (ap_valid_q && ap_write_q)
    begin
      unique case (ap_addr_q)
        REG_CTRL: ctrl_d = hwdata[1:0];
        REG_TIM0: tim0_d = hwdata;
        REG_TIM1: tim1_d = hwdata;
        default: ;
      endcase
    end
    if (ap_valid_d && !hwrite)
    begin
      unique case (haddr[7:0])
        REG_CTRL: rdata_d = {30'h0, ctrl_q};
        REG_STATUS: rdata_d = {22'h0, mr3_q[1:0], 1'b0, fb_q[1:0], rtt_dqs_q, mpr_en,
                               qoff, odt_ok, wl_on};
        REG_TIM0: rdata_d = tim0_q;
        REG_TIM1: rdata_d = tim1_q;
        REG_MR1: rdata_d = {18'h0, mr1_q};
        REG_MR3: rdata_d = {29'h0, mr3_q};
        default: rdata_d = 32'h0;
      endcase
    end

    // Mode register commands and the leveling phase.
    if (cmd == CMD_MRS && ba == MR1_SEL)
    begin
      if (wl_on && !addr[MR1_WL_BIT])
      begin
        mr1_d = (mr1_q & ~MR1_EXIT_MASK) | (addr & MR1_EXIT_MASK);
        mr1_d[MR1_WL_BIT] = 1'b0;
        wl_d = WL_EXIT;
        cnt_d = fld8(tim0_q, TIM0_MOD_LSB);
      end
      else if (wl_on)
      begin
        mr1_d[MR1_QOFF_BIT] = addr[MR1_QOFF_BIT];
      end
      else
      begin
        mr1_d = addr;
        if (addr[MR1_WL_BIT])
        begin
          wl_d = WL_SETTLE;
          cnt_d = fld8(tim0_q, TIM0_MOD_LSB);
          seen_d = '0;
          pend_d = '0;
        end
      end
    end
    else if (cmd == CMD_MRS && ba == MR3_SEL)
    begin
      mr3_d = addr[2:0];
    end
    else if ((wl_q == WL_SETTLE || wl_q == WL_EXIT) && cnt_q > 8'h1)
    begin
      cnt_d = cnt_q - 8'h1;
    end
    else if (wl_q == WL_SETTLE)
    begin
      wl_d = WL_READY;
    end
    else if (wl_q == WL_EXIT)
    begin
      wl_d = WL_OFF;
    end

    // In leveling, strobe termination follows ODT only once accepted and after the enable delay; outside leveling it follows ODT.
    if (!(odt_ok && odt))
    begin
      dqsen_d = fld8(tim0_q, TIM0_WLDQSEN_LSB);
      rtt_dqs_d = wl_on ? 1'b0 : odt;
    end
    else if (dqsen_q > 8'h1)
    begin
      dqsen_d = dqsen_q - 8'h1;
      rtt_dqs_d = 1'b0;
    end
    else
    begin
      rtt_dqs_d = 1'b1;
    end
    rtt_dq_d = wl_on ? 1'b0 : odt;

    // Each lane samples CK on its own rising strobe and reports after tWLO.
    for (int i = 0; i < LANES; i++)
    begin
      if (wl_on && dqs[i] && !dqs_prev_q[i])
      begin
        smp_d[i] = ck_level;
        pend_d[i] = 1'b1;
        wlo_d[i] = fld8(tim0_q, TIM0_WLO_LSB);
      end
      else if (pend_q[i] && wlo_q[i] > 8'h1)
      begin
        wlo_d[i] = wlo_q[i] - 8'h1;
      end
      else if (pend_q[i])
      begin
        pend_d[i] = 1'b0;
        fb_d[i] = smp_q[i];
        seen_d[i] = 1'b1;
      end
    end

    // Array access and redirected reads.
    if (beats_q != 4'h0)
    begin
      beats_d = beats_q - 4'h1;
      beat_idx_d = beat_idx_q + 3'h1;
    end
    if (cmd == CMD_RD && mpr_en)
    begin
      beats_d = addr[ADDR_BC_BIT] ? BURST_BL8 : BURST_BC4;
      beat_idx_d = addr[ADDR_ORDER_BIT] ? NIBBLE_UPPER : 3'h0;
      burst_loc_d = mr3_q[1:0];
    end
    else if (cmd == CMD_RD)
    begin
      rd_d = 1'b1;
      ap_d = addr[ADDR_AP_BIT];
    end
    else if (cmd == CMD_WR && !mpr_en)
    begin
      wr_d = 1'b1;
    end

    // Data pin values and enables, per lane.
    for (int i = 0; i < LANES; i++)
    begin
      oe_n_d[i] = 1'b1;
      lane_val = 8'h00;
      if (wl_on && !qoff)
      begin
        oe_n_d[i] = 1'b0;
        if (seen_q[i] && ctrl_q[CTRL_PRIME_BIT])
        begin
          lane_val = {7'h00, fb_q[i]};
        end
        else if (seen_q[i])
        begin
          lane_val = {8{fb_q[i]}};
        end
      end
      else if (wl_q == WL_EXIT && !qoff)
      begin
        oe_n_d[i] = 1'b0;
      end
      else if (beats_q != 4'h0 && !qoff)
      begin
        oe_n_d[i] = 1'b0;
        bit_now = (burst_loc_q == LOC_CAL) ? MPR_CAL_PATTERN[beat_idx_q] : 1'b0;
        lane_val = ctrl_q[CTRL_MPR_ZERO_BIT] ? {7'h00, bit_now} : {8{bit_now}};
      end
      dq_d[8*i +: 8] = lane_val;
    end
  end

  // Reset clears every mode, including an enabled MPR.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
      rdata_q <= 32'h0;
      ctrl_q <= CTRL_RST;
      tim0_q <= TIM0_RST;
      tim1_q <= TIM1_RST;
      mr1_q <= MR1_RST;
      mr3_q <= MR3_RST;
      wl_q <= WL_OFF;
      cnt_q <= 8'h00;
      dqsen_q <= 8'h00;
      rtt_dqs_q <= 1'b0;
      rtt_dq_q <= 1'b0;
      dqs_prev_q <= '0;
      smp_q <= '0;
      pend_q <= '0;
      fb_q <= '0;
      seen_q <= '0;
      for (int i = 0; i < LANES; i++)
      begin
        wlo_q[i] <= 8'h00;
      end
      beats_q <= 4'h0;
      beat_idx_q <= 3'h0;
      burst_loc_q <= 2'h0;
      dq_q <= '0;
      oe_n_q <= '1;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ap_q <= 1'b0;
    end
    else
    begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_addr_q <= ap_addr_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      tim0_q <= tim0_d;
      tim1_q <= tim1_d;
      mr1_q <= mr1_d;
      mr3_q <= mr3_d;
      wl_q <= wl_d;
      cnt_q <= cnt_d;
      dqsen_q <= dqsen_d;
      rtt_dqs_q <= rtt_dqs_d;
      rtt_dq_q <= rtt_dq_d;
      dqs_prev_q <= dqs_prev_d;
      smp_q <= smp_d;
      pend_q <= pend_d;
      fb_q <= fb_d;
      seen_q <= seen_d;
      wlo_q <= wlo_d;
      beats_q <= beats_d;
      beat_idx_q <= beat_idx_d;
      burst_loc_q <= burst_loc_d;
      dq_q <= dq_d;
      oe_n_q <= oe_n_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      ap_q <= ap_d;
    end
  end

endmodule

// file: rtl/ddtm_pkg.sv
// Constants, register map and types shared by the training-mode block.
package ddtm_pkg;

  // Clock rate and the timing figures in nanoseconds.
  localparam int CLK_MHZ = 250;
  localparam int T_MOD_NS = 60;
  localparam int T_MRD_NS = 16;
  localparam int T_WLO_NS = 8;
  localparam int T_WLDQSEN_NS = 100;
  localparam int T_WLMRD_NS = 160;
  localparam int T_RP_NS = 16;

  // Least times round up to whole cycles, never below one.
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [7:0] TMOD_CYC = 8'(ns_to_cyc(T_MOD_NS));
  localparam logic [7:0] TMRD_CYC = 8'(ns_to_cyc(T_MRD_NS));
  localparam logic [7:0] TWLO_CYC = 8'(ns_to_cyc(T_WLO_NS));
  localparam logic [7:0] TWLDQSEN_CYC = 8'(ns_to_cyc(T_WLDQSEN_NS));
  localparam logic [7:0] TWLMRD_CYC = 8'(ns_to_cyc(T_WLMRD_NS));
  localparam logic [7:0] TRP_CYC = 8'(ns_to_cyc(T_RP_NS));

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TIM0 = 8'h08;
  localparam logic [7:0] REG_TIM1 = 8'h0c;
  localparam logic [7:0] REG_MR1 = 8'h10;
  localparam logic [7:0] REG_MR3 = 8'h14;

  // Control register fields and reset value.
  localparam int CTRL_PRIME_BIT = 0;
  localparam int CTRL_MPR_ZERO_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // Timing register layout: byte fields, reset values from the figures above.
  localparam int TIM0_MOD_LSB = 0;
  localparam int TIM0_MRD_LSB = 8;
  localparam int TIM0_WLO_LSB = 16;
  localparam int TIM0_WLDQSEN_LSB = 24;
  localparam int TIM1_WLMRD_LSB = 0;
  localparam int TIM1_RP_LSB = 8;
  localparam logic [31:0] TIM0_RST = {TWLDQSEN_CYC, TWLO_CYC, TMRD_CYC, TMOD_CYC};
  localparam logic [31:0] TIM1_RST = {16'h0000, TRP_CYC, TWLMRD_CYC};

  // Status register fields.
  localparam int STAT_WL_BIT = 0;
  localparam int STAT_ODT_OK_BIT = 1;
  localparam int STAT_QOFF_BIT = 2;
  localparam int STAT_MPR_BIT = 3;
  localparam int STAT_RTT_DQS_BIT = 4;
  localparam int STAT_FB_LSB = 5;
  localparam int STAT_LOC_LSB = 8;

  // Mode register bit positions and reset values.
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR3_SEL = 3'h3;
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR3_MPR_BIT = 2;
  localparam logic [13:0] MR1_EXIT_MASK = 14'h1266;
  localparam logic [13:0] MR1_RST = 14'h0000;
  localparam logic [2:0] MR3_RST = 3'h0;
  localparam int ADDR_AP_BIT = 10;
  localparam int ADDR_BC_BIT = 12;
  localparam int ADDR_ORDER_BIT = 2;

  // Multi purpose register contents and burst lengths.
  localparam logic [1:0] LOC_CAL = 2'h0;
  localparam logic [7:0] MPR_CAL_PATTERN = 8'haa;
  localparam logic [3:0] BURST_BL8 = 4'h8;
  localparam logic [3:0] BURST_BC4 = 4'h4;
  localparam logic [2:0] NIBBLE_UPPER = 3'h4;

  // Command codes from {ras_n, cas_n, we_n} with the chip selected.
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_ZQ = 3'b110,
    CMD_NOP = 3'b111
  } ddtm_cmd_type;

  // Write leveling phases.
  typedef enum logic [1:0] {
    WL_OFF = 2'b00,
    WL_SETTLE = 2'b01,
    WL_READY = 2'b10,
    WL_EXIT = 2'b11
  } ddtm_wl_type;

endpackage

// file: testbench/ddtm_training_checker.sv
// Assertion checker for the training-mode block.
`timescale 1ns/1ps
module ddtm_chk
  import ddtm_pkg::*;
#(
  parameter int LANES = 2
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Command and strobe pins.
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  input wire logic odt,
  input wire logic ck_level,
  input wire logic [LANES-1:0] dqs,
  // Device outputs.
  input wire logic [8*LANES-1:0] dq_o,
  input wire logic [LANES-1:0] dq_oe_n,
  input wire logic rtt_dqs_on,
  input wire logic rtt_dq_on,
  input wire logic array_rd,
  input wire logic array_wr,
  input wire logic array_ap,
  input wire logic mpr_active
);
  logic mrs1, mrs3, rd_c, wr_c;
  logic wl_q, wl_d, qoff_q, qoff_d, mpr_q, mpr_d, cap_q, cap_d, dqp_q;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  assign mrs1 = !cs_n && {ras_n, cas_n, we_n} == CMD_MRS && ba == MR1_SEL;
  assign mrs3 = !cs_n && {ras_n, cas_n, we_n} == CMD_MRS && ba == MR3_SEL;
  assign rd_c = !cs_n && {ras_n, cas_n, we_n} == CMD_RD;
  assign wr_c = !cs_n && {ras_n, cas_n, we_n} == CMD_WR;
  // Tracks mode bits and the level caught by the last lane 0 strobe.
  always_comb
  begin
    wl_d = wl_q;
    qoff_d = qoff_q;
    mpr_d = mpr_q;
    cap_d = (wl_q && dqs[0] && !dqp_q) ? ck_level : cap_q;
    if (mrs1)
    begin
      wl_d = addr[MR1_WL_BIT];
      qoff_d = addr[MR1_QOFF_BIT];
    end
    if (mrs3)
      mpr_d = addr[MR3_MPR_BIT];
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      {wl_q, qoff_q, mpr_q, cap_q, dqp_q} <= 5'h00;
    else
      {wl_q, qoff_q, mpr_q, cap_q, dqp_q} <= {wl_d, qoff_d, mpr_d, cap_d, dqs[0]};
  end
  a_rd_array: assert property (rd_c && !mpr_q
    |=> array_rd && array_ap == $past(addr[ADDR_AP_BIT]))
    else $error("array read missing");
  a_rd_mpr: assert property (rd_c && mpr_q |=> !array_rd)
    else $error("array read in mpr mode");
  a_mpr_burst: assert property (rd_c && mpr_q |-> ##[1:3] mpr_active)
    else $error("no mpr burst");
  a_wr_array: assert property (wr_c && !mpr_q |=> array_wr)
    else $error("array write missing");
  a_wr_mpr: assert property (wr_c && mpr_q |=> !array_wr)
    else $error("write in mpr mode");
  a_dq_term_off: assert property (wl_q && $past(wl_q) |-> !rtt_dq_on)
    else $error("dq termination in leveling");
  a_dqs_term_off: assert property (wl_q && !odt |=> !rtt_dqs_on)
    else $error("strobe termination stuck");
  a_odt_wait: assert property ($rose(wl_q) && !odt && !$past(odt) |-> !rtt_dqs_on [*8])
    else $error("odt taken early");
  a_fb_level: assert property (wl_q && $past(wl_q) && !qoff_q && dqs[0] && !dqp_q
    |-> ##[1:8] dq_o[0] == cap_q)
    else $error("feedback wrong");
  a_qoff_hold: assert property (qoff_q && $past(qoff_q) |-> &dq_oe_n)
    else $error("outputs on while disabled");
endmodule
bind ddtm_training ddtm_chk #(.LANES(LANES)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
  .ck_level(ck_level), .dqs(dqs), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .rtt_dqs_on(rtt_dqs_on),
  .rtt_dq_on(rtt_dq_on), .array_rd(array_rd), .array_wr(array_wr), .array_ap(array_ap),
  .mpr_active(mpr_active));

// file: testbench/ddtm_ctrl_model.sv
// Memory controller model driving commands, termination request and strobes.
`timescale 1ns/1ps
module ddtm_ctrl_model
  import ddtm_pkg::*;
(
  // Clock.
  input wire logic hclk,
  // Command pins.
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr,
  // Termination and strobes.
  output logic odt,
  output logic ck_level,
  output logic [1:0] dqs
);
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 3'h0;
    addr = 14'h0000;
    odt = 1'b0;
    ck_level = 1'b0;
    dqs = 2'h0;
  end
  // One command for one cycle, then deselect with the bus inverted.
  task automatic cmd(input ddtm_cmd_type c, input logic [2:0] b,
                     input logic [13:0] a);
    @(posedge hclk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge hclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    ba <= ~b;
    addr <= ~a;
  endtask
  // In leveling, callers raise it only after the device reports acceptance.
  task automatic set_odt(input logic v);
    @(posedge hclk);
    odt <= v;
  endtask
  // A single pulse on the chosen lanes, then a gap for the feedback.
  task automatic strobe(input logic [1:0] m, input logic ck);
    @(posedge hclk);
    dqs <= m;
    ck_level <= ck;
    repeat (3) @(posedge hclk);
    dqs <= 2'h0;
    ck_level <= ~ck;
    repeat (12) @(posedge hclk);
  endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the training-mode block.
`timescale 1ns/1ps
module tb;
  import ddtm_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans, lv, dq_oe_n, dqs;
  logic [2:0] hsize, ba;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic cs_n, ras_n, cas_n, we_n, odt, ck_level, pm;
  logic [13:0] addr;
  logic [15:0] dq_o;
  logic rtt_dqs_on, rtt_dq_on, array_rd, array_wr, array_ap, mpr_active;
  int fails, checks, cyc, i, k, m, c;
  assign hready = hreadyout;
  ddtm_training #(.LANES(2)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .ck_level(ck_level), .dqs(dqs), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .rtt_dqs_on(rtt_dqs_on),
    .rtt_dq_on(rtt_dq_on), .array_rd(array_rd), .array_wr(array_wr), .array_ap(array_ap),
    .mpr_active(mpr_active));
  ddtm_ctrl_model model_u (.hclk(hclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .ck_level(ck_level), .dqs(dqs));
  task automatic stop_test;
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [15:0] fb(input logic [1:0] v, input logic p);
    fb = {p ? {7'h0, v[1]} : {8{v[1]}}, p ? {7'h0, v[0]} : {8{v[0]}}};
  endfunction
  function automatic logic [7:0] beat(input logic [1:0] loc, input int idx, input logic z);
    logic b;
    b = (loc == LOC_CAL) ? MPR_CAL_PATTERN[idx] : 1'b0;
    beat = z ? {7'h0, b} : {8{b}};
  endfunction
  task automatic burst(input logic [1:0] loc, input logic [13:0] a, input logic z);
    int n, s;
    n = a[ADDR_BC_BIT] ? 8 : 4;
    s = a[ADDR_ORDER_BIT] ? 4 : 0;
    model_u.cmd(CMD_RD, 3'h0, a);
    for (k = 0; k < 10 && mpr_active !== 1'b1; k++) @(negedge hclk);
    // Beat data follow the burst count by one register stage.
    @(negedge hclk);
    for (k = 0; k < n; k++)
    begin
      chk(dq_o, {16'h0, beat(loc, s + k, z), beat(loc, s + k, z)});
      @(negedge hclk);
    end
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fails++;
      stop_test;
    end
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, cyc, fails, checks} = '0;
    hsize = 3'h2;
    k = $urandom(25733);
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk({dq_oe_n, rtt_dqs_on, rtt_dq_on, mpr_active, hresp, hreadyout}, 32'h61);
    rdc(REG_TIM1, TIM1_RST);
    rdc(REG_TIM0, TIM0_RST);
    rdc(8'h40, 32'h0);
    bus(1'b1, REG_STATUS, 32'hffff_ffff);
    rdc(REG_STATUS, 32'h0);
    m = 8 + $urandom % 8;
    c = 1 + $urandom % 8;
    rdc(REG_TIM0, TIM0_RST);
    bus(1'b1, REG_TIM0, {8'(c), 8'h02, TMRD_CYC, 8'(m)});
    rdc(REG_TIM0, {8'(c), 8'h02, TMRD_CYC, 8'(m)});
    model_u.cmd(CMD_MRS, MR1_SEL, 14'h0080);
    rd = 32'h0;
    for (i = 0; i < 20 && rd[STAT_ODT_OK_BIT] !== 1'b1; i++) bus(1'b0, REG_STATUS, 32'h0);
    chk(rd[4:0], 5'h03);
    model_u.set_odt(1'b1);
    for (k = 0; k < 40 && rtt_dqs_on !== 1'b1; k++) @(negedge hclk);
    chk({rtt_dqs_on, rtt_dq_on}, 2'b10);
    lv = 2'h0;
    pm = 1'b0;
    for (i = 0; i < 8; i++)
    begin
      if (i == 4)
        bus(1'b1, REG_CTRL, 32'h1);
      pm = (i >= 4);
      m = (i == 4) ? 3 : 1 + $urandom % 3;
      c = $urandom % 2;
      model_u.strobe(m[1:0], c[0]);
      for (k = 0; k < 2; k++) if (m[k]) lv[k] = c[0];
      chk({dq_oe_n, dq_o}, {2'b00, fb(lv, pm)});
    end
    model_u.cmd(CMD_MRS, MR1_SEL, 14'h1080);
    for (k = 0; k < 5 && dq_oe_n !== 2'b11; k++) @(negedge hclk);
    chk(dq_oe_n, 2'b11);
    model_u.set_odt(1'b0);
    for (k = 0; k < 5 && rtt_dqs_on !== 1'b0; k++) @(negedge hclk);
    chk(rtt_dqs_on, 1'b0);
    model_u.cmd(CMD_MRS, MR1_SEL, 14'h0262);
    rdc(REG_MR1, 32'h262);
    for (k = 0; k < 40 && dq_oe_n !== 2'b11; k++) @(negedge hclk);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({dq_oe_n, rd[0]}, 3'b110);
    model_u.set_odt(1'b1);
    for (k = 0; k < 5 && rtt_dq_on !== 1'b1; k++) @(negedge hclk);
    chk(rtt_dq_on, 1'b1);
    model_u.set_odt(1'b0);
    model_u.cmd(CMD_RD, 3'h2, 14'h0400);
    @(negedge hclk);
    chk({array_rd, array_ap}, 2'b11);
    model_u.cmd(CMD_WR, 3'h0, 14'h0000);
    model_u.cmd(CMD_MRS, MR3_SEL, 14'h0004);
    rdc(REG_MR3, 32'h4);
    burst(LOC_CAL, 14'h1000, 1'b0);
    burst(LOC_CAL, 14'h0404, 1'b0);
    bus(1'b1, REG_CTRL, 32'h2);
    burst(LOC_CAL, 14'h0000, 1'b1);
    model_u.cmd(CMD_WR, 3'h0, 14'h0000);
    model_u.cmd(CMD_MRS, MR3_SEL, 14'h0005);
    burst(2'h1, 14'h1000, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk({rd[9:8], rd[3]}, 3'b011);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(REG_MR3, 32'h0);
    model_u.cmd(CMD_MRS, MR3_SEL, 14'h0003);
    model_u.cmd(CMD_RD, 3'h0, 14'h0000);
    @(negedge hclk);
    chk(array_rd, 1'b1);
    stop_test;
  end
endmodule
